//--- logic/ato_pkg.sv
// shared constants and carrier types for the accumulator transfer block
`default_nettype none
package ato_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int MEM_DEPTH = 16;
  // byte offsets of the software-visible registers
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_PTR = 8'h08;
  localparam logic [7:0] OFF_IRQ = 8'h0C;
  localparam logic [7:0] OFF_WAKE = 8'h10;
  localparam logic [7:0] OFF_TIMER = 8'h14;
  localparam logic [7:0] OFF_CONV = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1C;
  localparam logic [1:0] MEM_PAGE = 2'h1;
  // field positions (lsb of each nibble or field)
  localparam int ACC_A_LSB = 0;
  localparam int ACC_B_LSB = 4;
  localparam int PTR_X_LSB = 0;
  localparam int PTR_Y_LSB = 4;
  localparam int PTR_Z_LSB = 8;
  localparam int PTR_D_LSB = 12;
  localparam int PTR_SP_LSB = 16;
  localparam int PTR_CY_BIT = 20;
  localparam int IRQ_V1_LSB = 0;
  localparam int IRQ_V2_LSB = 4;
  localparam int IRQ_I1_LSB = 8;
  localparam int WAKE_K0_LSB = 0;
  localparam int WAKE_K1_LSB = 4;
  localparam int WAKE_K2_LSB = 8;
  localparam int TIM_W1_LSB = 0;
  localparam int TIM_W2_LSB = 4;
  localparam int TIM_W6_LSB = 8;
  localparam int CONV_Q1_LSB = 0;
  localparam int CONV_MR_LSB = 4;
  localparam int CONV_AD_LSB = 8;
  localparam int STAT_REF_LSB = 0;
  localparam int STAT_UNK_BIT = 8;
  localparam int MODE_SEL_BIT = 3;
  // reset values
  localparam logic [3:0] RST_NIB = 4'h0;
  localparam logic [9:0] RST_AD = 10'h000;
  localparam logic [7:0] RST_REF = 8'h00;
  localparam logic [9:0] RST_OPC = 10'h000;
  // instruction words of the transfer group
  localparam logic [9:0] OPC_LOAD_REF = 10'h29D;
  localparam logic [9:0] OPC_READ_I1 = 10'h253;
  localparam logic [9:0] OPC_READ_K0 = 10'h256;
  localparam logic [9:0] OPC_READ_K1 = 10'h259;
  localparam logic [9:0] OPC_READ_K2 = 10'h25A;
  localparam logic [9:0] OPC_READ_LA = 10'h249;
  localparam logic [5:0] OPC_MEM_HI = 6'h2C;
  localparam logic [9:0] OPC_READ_MR = 10'h252;
  localparam logic [9:0] OPC_READ_Q1 = 10'h244;
  localparam logic [9:0] OPC_READ_SP = 10'h050;
  localparam logic [9:0] OPC_READ_V1 = 10'h054;
  localparam logic [9:0] OPC_READ_V2 = 10'h055;
  localparam logic [9:0] OPC_READ_W1 = 10'h24B;
  localparam logic [9:0] OPC_READ_W2 = 10'h24C;
  localparam logic [9:0] OPC_READ_W6 = 10'h250;
  localparam logic [9:0] OPC_READ_X = 10'h052;
  localparam logic [9:0] OPC_READ_Y = 10'h01F;
  localparam logic [9:0] OPC_READ_Z = 10'h053;
  localparam logic [9:0] OPC_LOAD_D = 10'h029;

  typedef enum logic [4:0] {
    OP_NOP, OP_REF, OP_I1, OP_V1, OP_V2, OP_K0, OP_K1, OP_K2, OP_LA, OP_MEM,
    OP_MR, OP_Q1, OP_SP, OP_W1, OP_W2, OP_W6, OP_X, OP_Y, OP_Z, OP_D
  } ato_op_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } ato_apb_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } ato_apb_rsp_s;

  typedef struct packed {
    ato_op_e op;
    logic [3:0] imm;
    logic known;
  } ato_dec_s;
endpackage
`default_nettype wire

//--- logic/ato_decode.sv
// instruction word decoder for the transfer group
`timescale 1ns/10ps
`default_nettype none
module ato_decode (
  input wire logic [9:0] opcode,
  output ato_pkg::ato_dec_s dec
);
  import ato_pkg::*;

  // one-word opcodes map one to one; the memory load carries its immediate
  always_comb begin
    dec.imm = opcode[3:0];
    dec.known = 1'b1;
    dec.op = OP_NOP;
    if (opcode[9:4] == OPC_MEM_HI) begin
      dec.op = OP_MEM;
    end else begin
      unique case (opcode)
        OPC_LOAD_REF: dec.op = OP_REF;
        OPC_READ_I1: dec.op = OP_I1;
        OPC_READ_V1: dec.op = OP_V1;
        OPC_READ_V2: dec.op = OP_V2;
        OPC_READ_K0: dec.op = OP_K0;
        OPC_READ_K1: dec.op = OP_K1;
        OPC_READ_K2: dec.op = OP_K2;
        OPC_READ_LA: dec.op = OP_LA;
        OPC_READ_MR: dec.op = OP_MR;
        OPC_READ_Q1: dec.op = OP_Q1;
        OPC_READ_SP: dec.op = OP_SP;
        OPC_READ_W1: dec.op = OP_W1;
        OPC_READ_W2: dec.op = OP_W2;
        OPC_READ_W6: dec.op = OP_W6;
        OPC_READ_X: dec.op = OP_X;
        OPC_READ_Y: dec.op = OP_Y;
        OPC_READ_Z: dec.op = OP_Z;
        OPC_LOAD_D: dec.op = OP_D;
        default: dec.known = 1'b0; // words outside the group act as no-op
      endcase
    end
  end
endmodule
`default_nettype wire

//--- logic/ato_cmp_ref.sv
// comparator reference register, loaded only in comparator mode
`timescale 1ns/10ps
`default_nettype none
module ato_cmp_ref (
  input wire logic clk,
  input wire logic srst,
  input wire logic load,
  input wire logic modeSel,
  input wire logic [3:0] hiNib,
  input wire logic [3:0] loNib,
  output logic [7:0] refOut
);
  import ato_pkg::*;

  logic [7:0] ref_reg;
  logic [7:0] ref_next;

  // conversion mode swallows the load entirely, so the register holds
  assign ref_next = (load && modeSel) ? {hiNib, loNib} : ref_reg; // [RULE1] [RULE2]
  assign refOut = ref_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      ref_reg <= RST_REF;
    end else begin
      ref_reg <= ref_next;
    end
  end
endmodule
`default_nettype wire

//--- logic/ato_core.sv
// accumulator transfer execution unit with apb register access
// Summary of operation
// [RULE1] reference load in conversion mode changes nothing, like a no-op
// [RULE2] comparator mode: reference upper nibble from B, lower from A
// [RULE3] converter control bit 3 selects mode: 0 conversion, 1 comparator
// [RULE4] three instructions copy the two interrupt controls and extra one into A
// [RULE5] three instructions copy each wakeup control register into A
// [RULE6] result read puts low two result bits in A3..A2, zeros A1..A0
// [RULE7] memory load copies nibble at pointer to A, then X becomes X xor immediate
// [RULE8] one instruction copies clock control into A, leaving it untouched
// [RULE9] one instruction copies converter control into A
// [RULE10] stack read puts pointer in A2..A0 and clears A3
// [RULE11] three instructions copy timer controls one, two, six into A
// [RULE12] one instruction copies X into A
// [RULE13] one instruction copies Y into A
// [RULE14] Z read puts Z in A1..A0 and clears A3..A2
// [RULE15] table pointer load takes A2..A0 into D, ignoring A3
// [RULE16] each is one word, one cycle, keeps carry, never skips
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module ato_core (
  input wire logic clk,
  input wire logic srst,
  input wire ato_pkg::ato_apb_req_s apbReq,
  output ato_pkg::ato_apb_rsp_s apbRsp,
  output logic [3:0] accOut,
  output logic [7:0] compareRef
);
  import ato_pkg::*;

  // architectural state
  logic [3:0] accA_reg;
  logic [3:0] regB_reg;
  logic [3:0] regX_reg;
  logic [3:0] regY_reg;
  logic [1:0] regZ_reg;
  logic [2:0] tabPtr_reg;
  logic [2:0] stackPtr_reg;
  logic carry_reg;
  // peripheral control registers, written by software only
  logic [3:0] irqCtlOne_reg;
  logic [3:0] irqCtlTwo_reg;
  logic [3:0] irqCtlExtra_reg;
  logic [3:0] wakeCtl0_reg;
  logic [3:0] wakeCtl1_reg;
  logic [3:0] wakeCtl2_reg;
  logic [3:0] timCtl1_reg;
  logic [3:0] timCtl2_reg;
  logic [3:0] timCtl6_reg;
  logic [3:0] convCtl_reg;
  logic [3:0] clkCtl_reg;
  logic [9:0] convResult_reg;
  logic [3:0] mem_reg [MEM_DEPTH];
  logic [9:0] lastOpc_reg;
  logic unknown_reg;
  ato_apb_rsp_s rsp_reg;
  ato_apb_rsp_s rsp_next;

  logic accessDone;
  logic wrAny;
  logic wrInstr;
  logic wrAcc;
  logic wrPtr;
  logic wrIrq;
  logic wrWake;
  logic wrTimer;
  logic wrConv;
  logic memHit;
  logic [3:0] memIdx;
  logic mapped;
  logic [31:0] wd;
  logic [31:0] readData;
  logic [3:0] memAtPtr;
  logic modeSel;
  logic exec;
  logic loadsAcc;
  logic [3:0] acc_next;
  logic [7:0] refVal;
  ato_dec_s dec;

  // apb decode: the write lands on the access edge, where pready is high
  assign accessDone = apbReq.psel & apbReq.penable & rsp_reg.pready;
  assign wrAny = accessDone & apbReq.pwrite & ~rsp_reg.pslverr;
  assign wd = apbReq.pwdata;
  assign memHit = (apbReq.paddr[7:6] == MEM_PAGE) && (apbReq.paddr[1:0] == 2'h0);
  assign memIdx = apbReq.paddr[5:2];
  assign wrInstr = wrAny && (apbReq.paddr == OFF_INSTR);
  assign wrAcc = wrAny && (apbReq.paddr == OFF_ACC);
  assign wrPtr = wrAny && (apbReq.paddr == OFF_PTR);
  assign wrIrq = wrAny && (apbReq.paddr == OFF_IRQ);
  assign wrWake = wrAny && (apbReq.paddr == OFF_WAKE);
  assign wrTimer = wrAny && (apbReq.paddr == OFF_TIMER);
  assign wrConv = wrAny && (apbReq.paddr == OFF_CONV);
  assign mapped = memHit || (apbReq.paddr == OFF_INSTR) || (apbReq.paddr == OFF_ACC) ||
                  (apbReq.paddr == OFF_PTR) || (apbReq.paddr == OFF_IRQ) ||
                  (apbReq.paddr == OFF_WAKE) || (apbReq.paddr == OFF_TIMER) ||
                  (apbReq.paddr == OFF_CONV) || (apbReq.paddr == OFF_STAT);

  // writing an instruction word executes it in that same single cycle
  assign exec = wrInstr; // [RULE16]

  ato_decode u_decode (
    .opcode(wd[9:0]),
    .dec(dec)
  );

  // data pointer addresses memory through Y
  assign memAtPtr = mem_reg[regY_reg];
  assign modeSel = convCtl_reg[MODE_SEL_BIT]; // [RULE3]

  // source selection for the accumulator
  always_comb begin
    acc_next = accA_reg;
    loadsAcc = 1'b1;
    unique case (dec.op)
      OP_I1: acc_next = irqCtlExtra_reg; // [RULE4]
      OP_V1: acc_next = irqCtlOne_reg; // [RULE4]
      OP_V2: acc_next = irqCtlTwo_reg; // [RULE4]
      OP_K0: acc_next = wakeCtl0_reg; // [RULE5]
      OP_K1: acc_next = wakeCtl1_reg; // [RULE5]
      OP_K2: acc_next = wakeCtl2_reg; // [RULE5]
      OP_LA: acc_next = {convResult_reg[1:0], 2'h0}; // [RULE6]
      OP_MEM: acc_next = memAtPtr; // [RULE7]
      OP_MR: acc_next = clkCtl_reg; // [RULE8]
      OP_Q1: acc_next = convCtl_reg; // [RULE9]
      OP_SP: acc_next = {1'b0, stackPtr_reg}; // [RULE10]
      OP_W1: acc_next = timCtl1_reg; // [RULE11]
      OP_W2: acc_next = timCtl2_reg; // [RULE11]
      OP_W6: acc_next = timCtl6_reg; // [RULE11]
      OP_X: acc_next = regX_reg; // [RULE12]
      OP_Y: acc_next = regY_reg; // [RULE13]
      OP_Z: acc_next = {2'h0, regZ_reg}; // [RULE14]
      OP_NOP, OP_REF, OP_D: loadsAcc = 1'b0;
    endcase
  end

  ato_cmp_ref u_cmp_ref (
    .clk(clk),
    .srst(srst),
    .load(exec && (dec.op == OP_REF)), // [RULE1] [RULE2]
    .modeSel(modeSel),
    .hiNib(regB_reg),
    .loNib(accA_reg),
    .refOut(refVal)
  );

  // read multiplexer; reserved bits read zero
  always_comb begin
    readData = 32'h0000_0000;
    if (memHit) begin
      readData[3:0] = mem_reg[memIdx];
    end else begin
      unique case (apbReq.paddr)
        OFF_INSTR: readData[9:0] = lastOpc_reg;
        OFF_ACC: begin
          readData[ACC_A_LSB +: 4] = accA_reg;
          readData[ACC_B_LSB +: 4] = regB_reg;
        end
        OFF_PTR: begin
          readData[PTR_X_LSB +: 4] = regX_reg;
          readData[PTR_Y_LSB +: 4] = regY_reg;
          readData[PTR_Z_LSB +: 2] = regZ_reg;
          readData[PTR_D_LSB +: 3] = tabPtr_reg;
          readData[PTR_SP_LSB +: 3] = stackPtr_reg;
          readData[PTR_CY_BIT] = carry_reg;
        end
        OFF_IRQ: begin
          readData[IRQ_V1_LSB +: 4] = irqCtlOne_reg;
          readData[IRQ_V2_LSB +: 4] = irqCtlTwo_reg;
          readData[IRQ_I1_LSB +: 4] = irqCtlExtra_reg;
        end
        OFF_WAKE: begin
          readData[WAKE_K0_LSB +: 4] = wakeCtl0_reg;
          readData[WAKE_K1_LSB +: 4] = wakeCtl1_reg;
          readData[WAKE_K2_LSB +: 4] = wakeCtl2_reg;
        end
        OFF_TIMER: begin
          readData[TIM_W1_LSB +: 4] = timCtl1_reg;
          readData[TIM_W2_LSB +: 4] = timCtl2_reg;
          readData[TIM_W6_LSB +: 4] = timCtl6_reg;
        end
        OFF_CONV: begin
          readData[CONV_Q1_LSB +: 4] = convCtl_reg;
          readData[CONV_MR_LSB +: 4] = clkCtl_reg;
          readData[CONV_AD_LSB +: 10] = convResult_reg;
        end
        OFF_STAT: begin
          readData[STAT_REF_LSB +: 8] = refVal;
          readData[STAT_UNK_BIT] = unknown_reg;
        end
        default: readData = 32'h0000_0000;
      endcase
    end
  end

  // zero-wait slave: pready rises in the access phase, data captured at setup
  always_comb begin
    rsp_next.pready = apbReq.psel & ~apbReq.penable;
    rsp_next.pslverr = apbReq.psel & ~apbReq.penable & ~mapped;
    rsp_next.prdata = (apbReq.psel & ~apbReq.penable & ~apbReq.pwrite) ? readData : 32'h0000_0000;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  // accumulator and B; an executed transfer has priority over nothing else,
  // since a single apb write is either an instruction or a data store
  always_ff @(posedge clk) begin
    if (srst) begin
      accA_reg <= RST_NIB;
      regB_reg <= RST_NIB;
    end else if (exec && loadsAcc) begin
      accA_reg <= acc_next;
    end else if (wrAcc) begin
      accA_reg <= wd[ACC_A_LSB +: 4];
      regB_reg <= wd[ACC_B_LSB +: 4];
    end
  end

  // pointer group; carry is never touched by an instruction of this group
  always_ff @(posedge clk) begin
    if (srst) begin
      regX_reg <= RST_NIB;
      regY_reg <= RST_NIB;
      regZ_reg <= RST_NIB[1:0];
      tabPtr_reg <= RST_NIB[2:0];
      stackPtr_reg <= RST_NIB[2:0];
      carry_reg <= 1'b0;
    end else if (exec) begin
      if (dec.op == OP_MEM) begin
        regX_reg <= regX_reg ^ dec.imm; // [RULE7]
      end
      if (dec.op == OP_D) begin
        tabPtr_reg <= accA_reg[2:0]; // [RULE15]
      end
    end else if (wrPtr) begin
      regX_reg <= wd[PTR_X_LSB +: 4];
      regY_reg <= wd[PTR_Y_LSB +: 4];
      regZ_reg <= wd[PTR_Z_LSB +: 2];
      tabPtr_reg <= wd[PTR_D_LSB +: 3];
      stackPtr_reg <= wd[PTR_SP_LSB +: 3];
      carry_reg <= wd[PTR_CY_BIT];
    end
  end

  // peripheral controls: reads of them by instruction leave them as they are
  always_ff @(posedge clk) begin
    if (srst) begin
      irqCtlOne_reg <= RST_NIB;
      irqCtlTwo_reg <= RST_NIB;
      irqCtlExtra_reg <= RST_NIB;
      wakeCtl0_reg <= RST_NIB;
      wakeCtl1_reg <= RST_NIB;
      wakeCtl2_reg <= RST_NIB;
      timCtl1_reg <= RST_NIB;
      timCtl2_reg <= RST_NIB;
      timCtl6_reg <= RST_NIB;
      convCtl_reg <= RST_NIB;
      clkCtl_reg <= RST_NIB;
      convResult_reg <= RST_AD;
    end else begin
      if (wrIrq) begin
        irqCtlOne_reg <= wd[IRQ_V1_LSB +: 4];
        irqCtlTwo_reg <= wd[IRQ_V2_LSB +: 4];
        irqCtlExtra_reg <= wd[IRQ_I1_LSB +: 4];
      end
      if (wrWake) begin
        wakeCtl0_reg <= wd[WAKE_K0_LSB +: 4];
        wakeCtl1_reg <= wd[WAKE_K1_LSB +: 4];
        wakeCtl2_reg <= wd[WAKE_K2_LSB +: 4];
      end
      if (wrTimer) begin
        timCtl1_reg <= wd[TIM_W1_LSB +: 4];
        timCtl2_reg <= wd[TIM_W2_LSB +: 4];
        timCtl6_reg <= wd[TIM_W6_LSB +: 4];
      end
      if (wrConv) begin
        convCtl_reg <= wd[CONV_Q1_LSB +: 4];
        clkCtl_reg <= wd[CONV_MR_LSB +: 4]; // [RULE8]
        convResult_reg <= wd[CONV_AD_LSB +: 10];
      end
    end
  end

  // memory nibbles, one flop group per entry
  genvar gi;
  generate
    for (gi = 0; gi < MEM_DEPTH; gi++) begin : g_mem
      always_ff @(posedge clk) begin
        if (srst) begin
          mem_reg[gi] <= RST_NIB;
        end else if (wrAny && memHit && (memIdx == 4'(gi))) begin
          mem_reg[gi] <= wd[3:0];
        end
      end
    end
  endgenerate

  // trace of the last executed word, flagging ones outside the group
  always_ff @(posedge clk) begin
    if (srst) begin
      lastOpc_reg <= RST_OPC;
      unknown_reg <= 1'b0;
    end else if (exec) begin
      lastOpc_reg <= wd[9:0];
      unknown_reg <= ~dec.known;
    end
  end

  assign apbRsp = rsp_reg;
  assign accOut = accA_reg;
  assign compareRef = refVal;
endmodule
`default_nettype wire

//--- sim/ato_core_props.sv
// port-level assertions for the transfer execution unit
`timescale 1ns/10ps
`default_nettype none
module ato_core_props
  import ato_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire ato_pkg::ato_apb_req_s apbReq,
  input wire ato_pkg::ato_apb_rsp_s apbRsp,
  input wire logic [3:0] accOut,
  input wire logic [7:0] compareRef
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic doneWr;
  logic instrWr;
  logic refLoadWr;
  logic modeSeen;
  // completed write, and completed write of an instruction word
  assign doneWr = apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready;
  assign instrWr = doneWr && (apbReq.paddr == OFF_INSTR);
  assign refLoadWr = instrWr && (apbReq.pwdata[9:0] == OPC_LOAD_REF);
  // mode bit as software last wrote it; the checker cannot see the register itself
  always_ff @(posedge clk) begin
    if (srst) begin
      modeSeen <= RST_NIB[MODE_SEL_BIT];
    end else if (doneWr && (apbReq.paddr == OFF_CONV)) begin
      modeSeen <= apbReq.pwdata[CONV_Q1_LSB + MODE_SEL_BIT];
    end
  end
  sequence s_setup;
    apbReq.psel && !apbReq.penable;
  endsequence
  sequence s_exec(opc);
    instrWr && (apbReq.pwdata[9:0] == opc);
  endsequence
  chk_ready_after_setup: assert property (s_setup |=> apbRsp.pready)
    else $error("pready missing after setup");
  chk_idle_quiet: assert property (!apbReq.psel |=> !apbRsp.pready && !apbRsp.pslverr)
    else $error("response while idle");
  chk_err_unmapped: assert property (s_setup ##0 (apbReq.paddr == 8'h20) |=> apbRsp.pslverr && apbRsp.prdata == 32'h0)
    else $error("unmapped address not refused");
  chk_rdata_idle: assert property (!apbRsp.pready |-> apbRsp.prdata == 32'h0)
    else $error("read data outside access");
  // mid-run reset may also move the reference, hence the srst escape
  chk_ref_cause: assert property ($changed(compareRef) |-> $past(srst) || $past(refLoadWr))
    else $error("reference changed without load");
  chk_ref_conv_hold: assert property (s_exec(OPC_LOAD_REF) ##0 !modeSeen |=> $stable(compareRef) && $stable(accOut))
    else $error("reference load acted in conversion mode");
  chk_ref_low_nib: assert property (s_exec(OPC_LOAD_REF) ##0 modeSeen |=> compareRef[3:0] == $past(accOut))
    else $error("reference low nibble not from accumulator");
  chk_sp_top_clear: assert property (s_exec(OPC_READ_SP) |-> ##2 accOut[3] == 1'b0)
    else $error("stack read left bit 3 set");
  chk_z_top_clear: assert property (s_exec(OPC_READ_Z) |-> ##2 accOut[3:2] == 2'b00)
    else $error("z read left upper bits set");
  chk_la_low_clear: assert property (s_exec(OPC_READ_LA) |-> ##2 accOut[1:0] == 2'b00)
    else $error("result read left low bits set");
  chk_acc_cause: assert property ($changed(accOut) |-> $past(doneWr) || $past(doneWr, 2) || $past(srst) || $past(srst, 2))
    else $error("accumulator changed without a write");
endmodule
bind ato_core ato_core_props u_ato_core_props (.clk(clk), .srst(srst), .apbReq(apbReq), .apbRsp(apbRsp),
  .accOut(accOut), .compareRef(compareRef));
`default_nettype wire

//--- sim/ato_core_tb_top.sv
// self-checking bench for the transfer execution unit
`timescale 1ns/10ps
`default_nettype none
module ato_core_tb_top;
  import ato_pkg::*;
  logic clk;
  logic srst;
  ato_apb_req_s apbReq;
  ato_apb_rsp_s apbRsp;
  logic [3:0] accOut;
  logic [7:0] compareRef;
  logic [31:0] rdData;
  logic rdErr;
  int errors;
  int tests_run;

  ato_core u_ato_core (.clk(clk), .srst(srst), .apbReq(apbReq), .apbRsp(apbRsp), .accOut(accOut),
    .compareRef(compareRef));

  // 125 MHz core clock
  initial clk = 1'b0;
  always #4 clk = ~clk;

  task automatic wrap_up;
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one transfer; an idle cycle first so psel is never assigned twice in one step
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    @(posedge clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: data};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (apbRsp.pready === 1'b1) break;
    end
    if (n == 16) begin
      errors++;
      $display("CHECK FAILED pready expected 1 seen 0");
      wrap_up();
    end
    rdData = apbRsp.prdata;
    rdErr = apbRsp.pslverr;
    apbReq <= '0;
  endtask

  task automatic exec(input logic [9:0] opc);
    apb(1'b1, OFF_INSTR, {22'h0, opc});
  endtask

  task automatic t_reset;
    apb(1'b0, OFF_ACC, 32'h0);
    check("acc reset", 32'h0, rdData);
    apb(1'b0, OFF_STAT, 32'h0);
    check("stat reset", 32'h0, rdData);
    check("mapped no error", 32'h0, {31'h0, rdErr});
    check("ref reset", 32'h0, {24'h0, compareRef});
    $display("test reset done");
  endtask

  // every accumulator read instruction, with A preloaded to all ones
  task automatic t_reads;
    logic [9:0] opc [16] = '{OPC_READ_V1, OPC_READ_V2, OPC_READ_I1, OPC_READ_K0, OPC_READ_K1, OPC_READ_K2,
      OPC_READ_W1, OPC_READ_W2, OPC_READ_W6, OPC_READ_MR, OPC_READ_Q1, OPC_READ_X, OPC_READ_Y, OPC_READ_Z,
      OPC_READ_SP, OPC_READ_LA};
    logic [3:0] exp [16] = '{4'h3, 4'h5, 4'hA, 4'h6, 4'h9, 4'hC, 4'hB, 4'h7, 4'hE, 4'hD, 4'h4, 4'h5, 4'hA,
      4'h2, 4'h6, 4'hC};
    apb(1'b1, OFF_IRQ, 32'h00000A53);
    apb(1'b1, OFF_WAKE, 32'h00000C96);
    apb(1'b1, OFF_TIMER, 32'h00000E7B);
    apb(1'b1, OFF_CONV, 32'h0002B7D4);
    apb(1'b1, OFF_PTR, 32'h000602A5);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, OFF_ACC, 32'h0000000F);
      exec(opc[i]);
      apb(1'b0, OFF_ACC, 32'h0);
      check("acc after read", {28'h0, exp[i]}, rdData);
      check("acc port", {28'h0, exp[i]}, {28'h0, accOut});
    end
    apb(1'b0, OFF_CONV, 32'h0);
    check("clock control kept", 32'h0002B7D4, rdData);
    apb(1'b0, OFF_PTR, 32'h0);
    check("pointers kept", 32'h000602A5, rdData);
    $display("test register reads done");
  endtask

  // reference load ignored unless the mode bit is set
  task automatic t_ref;
    apb(1'b1, OFF_ACC, 32'h00000096);
    apb(1'b1, OFF_CONV, 32'h00000007);
    exec(OPC_LOAD_REF);
    // the reference flop moves on the completing edge, so look only after a later transfer
    apb(1'b0, OFF_ACC, 32'h0);
    check("ref in conversion mode", 32'h0, {24'h0, compareRef});
    check("acc in conversion mode", 32'h00000096, rdData);
    apb(1'b1, OFF_CONV, 32'h00000008);
    exec(OPC_LOAD_REF);
    apb(1'b0, OFF_STAT, 32'h0);
    check("ref in comparator mode", 32'h00000096, {24'h0, compareRef});
    check("stat ref", 32'h00000096, rdData);
    $display("test reference load done");
  endtask

  // memory load with x xor, then table pointer load, carry set throughout
  task automatic t_mem_d;
    apb(1'b1, OFF_PTR, 32'h00100035);
    apb(1'b1, 8'h4C, 32'h0000000B);
    apb(1'b1, OFF_ACC, 32'h0);
    exec({OPC_MEM_HI, 4'h9});
    apb(1'b0, OFF_ACC, 32'h0);
    check("acc from memory", 32'h0000000B, rdData);
    apb(1'b0, OFF_PTR, 32'h0);
    check("x xor immediate", 32'h0010003C, rdData);
    apb(1'b1, OFF_ACC, 32'h0000000D);
    exec(OPC_LOAD_D);
    apb(1'b0, OFF_PTR, 32'h0);
    check("table pointer", 32'h0010503C, rdData);
    $display("test memory and table pointer done");
  endtask

  // refused accesses and an unknown instruction word
  task automatic t_err;
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped error", 32'h1, {31'h0, rdErr});
    check("unmapped data", 32'h0, rdData);
    apb(1'b1, 8'h41, 32'h0000000F);
    check("misaligned error", 32'h1, {31'h0, rdErr});
    apb(1'b1, OFF_STAT, 32'h000000FF);
    exec(10'h3FF);
    apb(1'b0, OFF_STAT, 32'h0);
    check("stat after unknown", 32'h00000196, rdData);
    apb(1'b0, OFF_ACC, 32'h0);
    check("acc after unknown", 32'h0000000D, rdData);
    $display("test refusals done");
  endtask

  initial begin
    apbReq = '0;
    srst = 1'b1;
    errors = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_reads();
    t_ref();
    t_mem_d();
    t_err();
    wrap_up();
  end
endmodule
`default_nettype wire
